//--- design/gpc_control_bank.sv
// Function
// RULE_01: Pin three level change raises event when enabled
// RULE_02: Event leaves for interrupt event and mask registers
// RULE_03: Pin three invert bit flips its polarity
// RULE_04: Pin three output enable drives, else high impedance
// RULE_05: Pin three value read returns live input
// RULE_06: Pin three value write sets driven level
// RULE_07: Pin two level change raises event when enabled
// RULE_08: Pin two invert bit flips its polarity
// RULE_09: Pin two output enable drives, else high impedance
// RULE_10: Pin two value read returns live input
// RULE_11: Pin two value write sets driven level
// RULE_12: Unused bits ignore writes, read zero
// RULE_13: Inputs synchronised; both edges count as change
//
// Top of the general pin control bank.
// Assumes the configuration-space decoder asserts cfg_wr_en or uses cfg_rd_data
// only for this register's offset; pads resolve drive from out and oe.
`timescale 1ns/1ps
module gpc_control_bank (
    input  wire logic        clock,
    input  wire logic        srst,
    input  wire logic        cfg_wr_en,
    input  wire logic [31:0] cfg_wr_data,
    output logic      [31:0] cfg_rd_data,
    input  wire logic        general_pin_two_in,
    output logic             general_pin_two_out,
    output logic             general_pin_two_oe,
    input  wire logic        general_pin_three_in,
    output logic             general_pin_three_out,
    output logic             general_pin_three_oe,
    output logic             general_pin_event
);
    logic [31:0] wr_kept;
    logic        pin_two_event_enable;
    logic        pin_two_invert;
    logic        pin_two_value;
    logic        pin_two_event;
    logic        pin_three_event_enable;
    logic        pin_three_invert;
    logic        pin_three_value;
    logic        pin_three_event;

    assign wr_kept = cfg_wr_data & gpc_pkg::CTRL_WRITE_MASK;  // RULE_12

    gpc_pin_slice u_pin_two (
        .clock            (clock),
        .srst             (srst),
        .wr_en            (cfg_wr_en),
        .wr_event_enable  (wr_kept[gpc_pkg::BIT_P2_EVT_EN]),
        .wr_invert        (wr_kept[gpc_pkg::BIT_P2_INVERT]),
        .wr_output_enable (wr_kept[gpc_pkg::BIT_P2_OE]),
        .wr_value         (wr_kept[gpc_pkg::BIT_P2_VALUE]),
        .pin_in           (general_pin_two_in),
        .pin_out          (general_pin_two_out),
        .pin_oe           (general_pin_two_oe),
        .event_enable     (pin_two_event_enable),
        .invert           (pin_two_invert),
        .read_value       (pin_two_value),
        .level_event      (pin_two_event)
    );

    gpc_pin_slice u_pin_three (
        .clock            (clock),
        .srst             (srst),
        .wr_en            (cfg_wr_en),
        .wr_event_enable  (wr_kept[gpc_pkg::BIT_P3_EVT_EN]),
        .wr_invert        (wr_kept[gpc_pkg::BIT_P3_INVERT]),
        .wr_output_enable (wr_kept[gpc_pkg::BIT_P3_OE]),
        .wr_value         (wr_kept[gpc_pkg::BIT_P3_VALUE]),
        .pin_in           (general_pin_three_in),
        .pin_out          (general_pin_three_out),
        .pin_oe           (general_pin_three_oe),
        .event_enable     (pin_three_event_enable),
        .invert           (pin_three_invert),
        .read_value       (pin_three_value),
        .level_event      (pin_three_event)
    );

    // Read data is registered so it is a clean flop output
    always_ff @(posedge clock) begin
        if (srst) begin
            cfg_rd_data <= gpc_pkg::CTRL_RESET;
        end else begin
            cfg_rd_data <= gpc_pkg::CTRL_RESET;                              // RULE_12
            cfg_rd_data[gpc_pkg::BIT_P3_EVT_EN] <= pin_three_event_enable;
            cfg_rd_data[gpc_pkg::BIT_P3_INVERT] <= pin_three_invert;
            cfg_rd_data[gpc_pkg::BIT_P3_OE]     <= general_pin_three_oe;
            cfg_rd_data[gpc_pkg::BIT_P3_VALUE]  <= pin_three_value;          // RULE_05
            cfg_rd_data[gpc_pkg::BIT_P2_EVT_EN] <= pin_two_event_enable;
            cfg_rd_data[gpc_pkg::BIT_P2_INVERT] <= pin_two_invert;
            cfg_rd_data[gpc_pkg::BIT_P2_OE]     <= general_pin_two_oe;
            cfg_rd_data[gpc_pkg::BIT_P2_VALUE]  <= pin_two_value;            // RULE_10
        end
    end

    // One-cycle pulse for the interrupt event register outside
    always_ff @(posedge clock) begin
        if (srst) begin
            general_pin_event <= 1'b0;
        end else begin
            general_pin_event <= pin_two_event | pin_three_event;  // RULE_02
        end
    end

    property p_reserved_zero;
        @(posedge clock) disable iff (srst)
        (cfg_rd_data & ~gpc_pkg::CTRL_WRITE_MASK) == 32'h0000_0000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set"); // RULE_12

    property p_event_out;
        @(posedge clock) disable iff (srst)
        (pin_two_event || pin_three_event) |=> general_pin_event;
    endproperty
    a_event_out: assert property (p_event_out) else $error("event not forwarded"); // RULE_02

    property p_three_oe;
        @(posedge clock) disable iff (srst)
        cfg_wr_en |=> general_pin_three_oe == $past(cfg_wr_data[gpc_pkg::BIT_P3_OE]);
    endproperty
    a_three_oe: assert property (p_three_oe) else $error("pin three oe wrong"); // RULE_04

    property p_two_oe;
        @(posedge clock) disable iff (srst)
        cfg_wr_en |=> general_pin_two_oe == $past(cfg_wr_data[gpc_pkg::BIT_P2_OE]);
    endproperty
    a_two_oe: assert property (p_two_oe) else $error("pin two oe wrong"); // RULE_09

    property p_three_read;
        @(posedge clock) disable iff (srst)
        1'b1 |=> cfg_rd_data[gpc_pkg::BIT_P3_VALUE] == $past(pin_three_value);
    endproperty
    a_three_read: assert property (p_three_read) else $error("pin three read wrong"); // RULE_05

    property p_three_invert;
        @(posedge clock) disable iff (srst)
        cfg_wr_en |=> ##1 general_pin_three_out ==
            ($past(cfg_wr_data[gpc_pkg::BIT_P3_VALUE], 2)
             ^ $past(cfg_wr_data[gpc_pkg::BIT_P3_INVERT], 2));
    endproperty
    a_three_invert: assert property (p_three_invert) else $error("pin three polarity"); // RULE_03 RULE_06

    // Read path for pin two mirrors pin three
    property p_two_read;
        @(posedge clock) disable iff (srst)
        1'b1 |=> cfg_rd_data[gpc_pkg::BIT_P2_VALUE] == $past(pin_two_value);
    endproperty
    a_two_read: assert property (p_two_read) else $error("pin two read wrong"); // RULE_10

    property p_two_drive;
        @(posedge clock) disable iff (srst)
        cfg_wr_en |=> ##1 general_pin_two_out ==
            ($past(cfg_wr_data[gpc_pkg::BIT_P2_VALUE], 2)
             ^ $past(cfg_wr_data[gpc_pkg::BIT_P2_INVERT], 2));
    endproperty
    a_two_drive: assert property (p_two_drive) else $error("pin two polarity"); // RULE_08 RULE_11

    // Setting bits read back as written; value bits follow the pins instead
    localparam logic [31:0] THREE_SETTINGS = (32'h0000_0001 << gpc_pkg::BIT_P3_EVT_EN)
                                           | (32'h0000_0001 << gpc_pkg::BIT_P3_INVERT)
                                           | (32'h0000_0001 << gpc_pkg::BIT_P3_OE);
    localparam logic [31:0] TWO_SETTINGS   = (32'h0000_0001 << gpc_pkg::BIT_P2_EVT_EN)
                                           | (32'h0000_0001 << gpc_pkg::BIT_P2_INVERT)
                                           | (32'h0000_0001 << gpc_pkg::BIT_P2_OE);

    property p_three_settings;
        @(posedge clock) disable iff (srst)
        cfg_wr_en |=> ##1
            (cfg_rd_data & THREE_SETTINGS) == ($past(cfg_wr_data, 2) & THREE_SETTINGS);
    endproperty
    a_three_settings: assert property (p_three_settings) // RULE_01 RULE_03 RULE_04
        else $error("pin three settings readback");

    property p_two_settings;
        @(posedge clock) disable iff (srst)
        cfg_wr_en |=> ##1
            (cfg_rd_data & TWO_SETTINGS) == ($past(cfg_wr_data, 2) & TWO_SETTINGS);
    endproperty
    a_two_settings: assert property (p_two_settings) // RULE_07 RULE_08 RULE_09
        else $error("pin two settings readback");

    // Pin seen changing, still enabled when the slice compares levels
    sequence s_three_change;
        $changed(general_pin_three_in) ##2 pin_three_event_enable;
    endsequence

    sequence s_two_change;
        $changed(general_pin_two_in) ##2 pin_two_event_enable;
    endsequence

    // Slice flop, then the output flop
    sequence s_pulse_out;
        ##2 general_pin_event;
    endsequence

    property p_three_event;
        @(posedge clock) disable iff (srst)
        s_three_change |-> s_pulse_out;
    endproperty
    a_three_event: assert property (p_three_event) else $error("pin three event lost"); // RULE_01

    property p_two_event;
        @(posedge clock) disable iff (srst)
        s_two_change |-> s_pulse_out;
    endproperty
    a_two_event: assert property (p_two_event) else $error("pin two event lost"); // RULE_07

    // A pulse needs a pin enabled two cycles earlier
    property p_event_gated;
        @(posedge clock) disable iff (srst)
        general_pin_event |-> $past(pin_two_event_enable, 2) || $past(pin_three_event_enable, 2);
    endproperty
    a_event_gated: assert property (p_event_gated) else $error("event from disabled pin"); // RULE_01 RULE_07

    // Out of reset the pins are released and nothing is reported
    property p_reset_state;
        @(posedge clock)
        srst |=> (cfg_rd_data == gpc_pkg::CTRL_RESET) && !general_pin_event
                 && !general_pin_two_oe && !general_pin_three_oe
                 && !general_pin_two_out && !general_pin_three_out;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("reset state wrong"); // RULE_04 RULE_09
endmodule : gpc_control_bank

//--- design/gpc_pkg.sv
// Package for the general pin control bank: field positions and reset values.
// Assumes a 32-bit configuration-space register port on the PCI clock.
package gpc_pkg;
    localparam int unsigned WIDTH           = 32;
    localparam logic [7:0]  CTRL_OFFSET     = 8'hfc;
    localparam int unsigned BIT_P3_EVT_EN   = 31;
    localparam int unsigned BIT_P3_INVERT   = 29;
    localparam int unsigned BIT_P3_OE       = 28;
    localparam int unsigned BIT_P3_VALUE    = 24;
    localparam int unsigned BIT_P2_EVT_EN   = 23;
    localparam int unsigned BIT_P2_INVERT   = 21;
    localparam int unsigned BIT_P2_OE       = 20;
    localparam int unsigned BIT_P2_VALUE    = 16;
    localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
    localparam logic [31:0] CTRL_WRITE_MASK = 32'hb1b1_0000;
endpackage : gpc_pkg

//--- design/gpc_pin_slice.sv
// One general pin: setting bits, input synchroniser, edge detector, pad drive.
// Assumes pin_in is asynchronous to clock; pad resolution is done outside.
`timescale 1ns/1ps
module gpc_pin_slice (
    input  wire logic clock,
    input  wire logic srst,
    input  wire logic wr_en,
    input  wire logic wr_event_enable,
    input  wire logic wr_invert,
    input  wire logic wr_output_enable,
    input  wire logic wr_value,
    input  wire logic pin_in,
    output logic      pin_out,
    output logic      pin_oe,
    output logic      event_enable,
    output logic      invert,
    output logic      read_value,
    output logic      level_event
);
    logic stored_value;
    logic sync_a;
    logic sync_b;
    logic last_level;

    always_ff @(posedge clock) begin
        if (srst) begin
            event_enable <= 1'b0;
            invert       <= 1'b0;
            pin_oe       <= 1'b0;
            stored_value <= 1'b0;
        end else if (wr_en) begin
            event_enable <= wr_event_enable;
            invert       <= wr_invert;
            pin_oe       <= wr_output_enable;   // RULE_04 RULE_09
            stored_value <= wr_value;           // RULE_06 RULE_11
        end
    end

    // Polarity applies on both directions so the read mirrors what was written
    always_ff @(posedge clock) begin
        if (srst) begin
            pin_out <= 1'b0;
        end else begin
            pin_out <= stored_value ^ invert;  // RULE_03 RULE_08
        end
    end

    // Two stages before any logic looks at the pin
    // No reset: chain follows the pin through reset, so release gives no false edge
    always_ff @(posedge clock) begin
        sync_a     <= pin_in;                   // RULE_13
        sync_b     <= sync_a;
        last_level <= sync_b;
    end

    assign read_value = sync_b ^ invert;        // RULE_05 RULE_10
    // Both edges count as a change
    always_ff @(posedge clock) begin
        if (srst) begin
            level_event <= 1'b0;
        end else begin
            level_event <= event_enable && (sync_b != last_level); // RULE_01 RULE_07 RULE_13
        end
    end

    property p_edge_event;
        @(posedge clock) disable iff (srst)
        (event_enable && (sync_b != last_level)) |=> level_event;
    endproperty
    a_edge_event: assert property (p_edge_event) else $error("edge missed"); // RULE_13

    property p_no_event_disabled;
        @(posedge clock) disable iff (srst)
        !$past(event_enable) |-> !level_event;
    endproperty
    a_no_event_disabled: assert property (p_no_event_disabled)
        else $error("event while disabled"); // RULE_01

    property p_drive;
        @(posedge clock) disable iff (srst)
        wr_en |=> (pin_oe == $past(wr_output_enable))
                  ##1 (pin_out == ($past(wr_value, 2) ^ $past(wr_invert, 2)));
    endproperty
    a_drive: assert property (p_drive) else $error("drive mismatch"); // RULE_06 RULE_11
endmodule : gpc_pin_slice

//--- verification/gpc_board_model.sv
// Board model for the two general pins: pull-up and an optional board driver.
// Assumes the device splits each pin into out and oe; two drivers read unknown.
`timescale 1ns/1ps
module gpc_board_model (
    input  wire logic [1:0] dev_out,
    input  wire logic [1:0] dev_oe,
    input  wire logic [1:0] board_oe,
    input  wire logic [1:0] board_lvl,
    output logic      [1:0] pin_level
);
    // Contention gives unknown so a wrong enable cannot hide
    always_comb begin
        for (int p = 0; p < 2; p++) begin
            case ({dev_oe[p], board_oe[p]})
                2'b10:   pin_level[p] = dev_out[p];
                2'b01:   pin_level[p] = board_lvl[p];
                2'b00:   pin_level[p] = 1'b1;
                default: pin_level[p] = 1'bx;
            endcase
        end
    end
endmodule : gpc_board_model

//--- verification/tb_top.sv
// Testbench for the general pin control bank: register writes, reads, pin events.
// Assumes the board model resolves each pin wire; index 1 is pin three.
`timescale 1ns/1ps
`define CHK(e, g) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
    $display("BAD t=%0t exp=%h got=%h", $time, (e), (g)); end end
module tb_top;
    logic        clock = 1'b0;
    logic        srst = 1'b1;
    logic        cfg_wr_en = 1'b0;
    logic [31:0] cfg_wr_data = 32'h0000_0000;
    logic [31:0] cfg_rd_data;
    logic [1:0]  pin_in, pin_out, pin_oe;
    logic [1:0]  board_oe = 2'b11;
    logic [1:0]  board_lvl = 2'b00;
    logic        general_pin_event;
    logic [31:0] words [7] = '{32'h0000_0000, 32'hffff_ffff, 32'h2020_0000, 32'h1101_0000,
                               32'h0011_0000, 32'h3030_0000, 32'h4e4e_ffff};
    int          bad_count = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    int          evts;

    gpc_control_bank dut (
        .clock                 (clock),
        .srst                  (srst),
        .cfg_wr_en             (cfg_wr_en),
        .cfg_wr_data           (cfg_wr_data),
        .cfg_rd_data           (cfg_rd_data),
        .general_pin_two_in    (pin_in[0]),
        .general_pin_two_out   (pin_out[0]),
        .general_pin_two_oe    (pin_oe[0]),
        .general_pin_three_in  (pin_in[1]),
        .general_pin_three_out (pin_out[1]),
        .general_pin_three_oe  (pin_oe[1]),
        .general_pin_event     (general_pin_event)
    );
    gpc_board_model board (
        .dev_out   (pin_out),
        .dev_oe    (pin_oe),
        .board_oe  (board_oe),
        .board_lvl (board_lvl),
        .pin_level (pin_in)
    );

    always #4 clock = ~clock;

    // Whole run needs about 115 cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 1000) begin
            bad_count++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : give_verdict

    task automatic wr(input logic [31:0] d);
        @(negedge clock);
        cfg_wr_en = 1'b1;
        cfg_wr_data = d;
        @(negedge clock);
        cfg_wr_en = 1'b0;
        repeat (4) @(negedge clock);
    endtask : wr

    // Read word from rules: value bits show the wire level through invert
    function automatic logic [31:0] exp_rd(input logic [31:0] d);
        logic [31:0] r;
        logic        w;
        r = d & 32'hb1b1_0000;
        for (int p = 0; p < 2; p++) begin
            w = r[20+8*p] ? (r[16+8*p] ^ r[21+8*p]) : (board_oe[p] ? board_lvl[p] : 1'b1);
            r[16+8*p] = w ^ r[21+8*p];
        end
        return r;
    endfunction : exp_rd

    task automatic evt(input int p, input logic lvl, input int n);
        @(negedge clock);
        board_lvl[p] = lvl;
        evts = 0;
        repeat (8) begin
            @(negedge clock);
            if (general_pin_event === 1'b1) evts++;
        end
        `CHK(n, evts)
    endtask : evt

    initial begin
        repeat (12) @(negedge clock);
        srst = 1'b0;
        repeat (4) @(negedge clock);
        `CHK(32'h0000_0000, cfg_rd_data)
        `CHK(2'b00, pin_oe)
        for (int k = 0; k < 7; k++) begin
            // Board stays off any pin driven before or after the write: no contention
            board_oe = ~({words[k][28], words[k][20]}
                         | ((k > 0) ? {words[k-1][28], words[k-1][20]} : 2'b00));
            board_lvl = k[1:0];
            wr(words[k]);
            `CHK(exp_rd(words[k]), cfg_rd_data)
            `CHK({words[k][28], words[k][20]}, pin_oe)
            `CHK({words[k][24] ^ words[k][29], words[k][16] ^ words[k][21]}, pin_out)
        end
        board_oe = 2'b11;
        board_lvl = 2'b00;
        wr(32'h8080_0000);
        evt(1, 1'b1, 1);
        evt(1, 1'b0, 1);
        evt(0, 1'b1, 1);
        wr(32'h0080_0000);
        evt(1, 1'b1, 0);
        evt(0, 1'b0, 1);
        give_verdict();
    end
endmodule : tb_top
